/* File: verilog/amp_prot_pkg.sv */
// constants shared by the protection and fault-control block
package amp_prot_pkg;
	// clock rate and short-check timing
	localparam int CLK_HZ = 50_000_000;
	localparam int SC_MS_PER_UF = 15;
	// longest time, so the cycle count rounds down
	localparam int SC_CYC_PER_UF = SC_MS_PER_UF * (CLK_HZ / 1000);
	// register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	// control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_BIG_PKG_BIT = 2;
	localparam int CTRL_CAP_LSB = 8;
	// control value after reset: bridged, larger package, 1 uF
	localparam logic [31:0] CTRL_RST = 32'h0000_0104;
	// output configuration codes
	localparam logic [1:0] MODE_BRIDGED = 2'h0;
	localparam logic [1:0] MODE_PARALLEL = 2'h1;
	localparam logic [1:0] MODE_SINGLE = 2'h2;
	// bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// number of synchronised pin inputs
	localparam int SYNC_W = 30;
	// synchroniser values after reset: reset pin and pulled-up lines high
	localparam logic [SYNC_W-1:0] SYNC_IDLE =
		{1'b1, {(SYNC_W-5){1'b0}}, 4'hf};
	// startup sequencer states
	typedef enum logic [1:0] {
		ST_POWER_UP,
		ST_SHORT_GND,
		ST_SHORT_PVDD,
		ST_RUN
	} seq_t;
endpackage : amp_prot_pkg

/* File: verilog/amp_protection_fault_control.sv */
// protection, fault signalling and startup short check of the power stage
//
// Overview of operation
// - bootstrap undervoltage turns off only its half-bridge
// - short check runs only at logic-supply startup
// - outputs high impedance while a short persists
// - check ground shorts first, then supply shorts
// - check length scales with filter capacitance
// - fault line low, reset ignored during check
// - clean check releases the fault line
// - device reset never restarts the short check
// - short check skipped in single-ended mode
// - larger package: two warnings plus shutdown
// - smaller package: one warning plus shutdown
// - thermal shutdown latches until reset asserted
// - power-on reset clears overload, holds circuits
// - logic or gate-drive supply undervoltage: all off, fault low
// - undervoltage recovers by itself when supplies return
// - reset low forces all half-bridges off
// - reset low: weak pulldown except single-ended
// - reset rising edge clears overload, restarts switching
// - overcurrent drives ready low
// - clip indication when output nears clipping
// - fault and warning lines are active-low open drain
// - faults go high impedance; most recover alone
// - local error turns off configuration-dependent group
`timescale 1ns/100ps
module amp_protection_fault_control
	import amp_prot_pkg::*;
#(
	parameter int SC_CYC_PER_UF_P = SC_CYC_PER_UF
)(
	// clock and bus reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// device reset pin and supply monitors
	input wire logic dev_reset_n,
	input wire logic logic_supply_ok,
	input wire logic [3:0] gate_drive_supply_ok,
	input wire logic [3:0] bootstrap_ok,
	// comparators
	input wire logic [3:0] short_to_gnd,
	input wire logic [3:0] short_to_supply,
	input wire logic [3:0] over_current_check,
	input wire logic temp_over_low,
	input wire logic temp_over_high,
	input wire logic temp_over_trip,
	input wire logic clip_near,
	// open-drain lines: wire level, drive value, enable (low drives)
	input wire logic fault_line_n_i,
	output logic fault_line_n_o,
	output logic fault_line_n_oe_n,
	input wire logic thermal_warn_low_n_i,
	output logic thermal_warn_low_n_o,
	output logic thermal_warn_low_n_oe_n,
	input wire logic thermal_warn_high_n_i,
	output logic thermal_warn_high_n_o,
	output logic thermal_warn_high_n_oe_n,
	input wire logic thermal_warn_n_i,
	output logic thermal_warn_n_o,
	output logic thermal_warn_n_oe_n,
	// power stage control and indications
	output logic [3:0] bridge_hiz,
	output logic [3:0] weak_pulldown,
	output logic ready,
	output logic clip_n
);
	// refuse a count too small for two phases or too big for the timer
	if (SC_CYC_PER_UF_P < 2 || SC_CYC_PER_UF_P > 30_000_000)
	begin : g_bad_cyc
		$error("short check cycles per uF out of range");
	end

	// synchroniser stages
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] pins_raw;
	// synchronised views
	logic rst_s, vdd_s, t_low_s, t_high_s, t_trip_s, clip_s;
	logic [3:0] gvdd_s, bst_s, sgnd_s, spv_s, oc_s, lines_s;

	assign pins_raw = {dev_reset_n, logic_supply_ok, gate_drive_supply_ok,
		bootstrap_ok, short_to_gnd, short_to_supply, over_current_check,
		temp_over_low, temp_over_high, temp_over_trip, clip_near,
		fault_line_n_i, thermal_warn_low_n_i, thermal_warn_high_n_i,
		thermal_warn_n_i};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync1_q[gi] <= SYNC_IDLE[gi];
					sync2_q[gi] <= SYNC_IDLE[gi];
				end
				else
				begin
					sync1_q[gi] <= pins_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	assign {rst_s, vdd_s, gvdd_s, bst_s, sgnd_s, spv_s, oc_s, t_low_s,
		t_high_s, t_trip_s, clip_s, lines_s} = sync2_q;

	// control register and its fields
	logic [31:0] ctrl_q, ctrl_d;
	logic [1:0] mode;
	logic big_pkg;
	logic [7:0] cap_uf;
	assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
	assign big_pkg = ctrl_q[CTRL_BIG_PKG_BIT];
	assign cap_uf = ctrl_q[CTRL_CAP_LSB +: 8];

	// protection state
	seq_t state_q, state_d;
	logic [31:0] cnt_q, cnt_d; // short-check phase timer
	logic therm_q, therm_d; // thermal shutdown latch
	logic [3:0] ovl_q, ovl_d; // overload latch per half-bridge
	logic rst_prev_q, rst_prev_d; // reset pin history
	logic [31:0] phase_lim; // cycles per check phase
	logic low_supply; // logic or gate-drive supply under threshold
	logic checking; // short check under way
	logic rst_rise;
	logic [3:0] ovl_grp; // overload spread to its group
	// output registers
	logic [3:0] hiz_q, hiz_d, pd_q, pd_d;
	logic fault_low_q, fault_low_d;
	logic wl_q, wl_d, wh_q, wh_d, wn_q, wn_d;
	logic ready_q, ready_d, clip_q, clip_d;

	// each of the two phases gets half the per-uF time
	assign phase_lim = 32'(cap_uf) * 32'(SC_CYC_PER_UF_P / 2);
	assign low_supply = !vdd_s || !(&gvdd_s);
	assign checking = (state_q == ST_SHORT_GND) ||
		(state_q == ST_SHORT_PVDD);
	assign rst_rise = rst_s && !rst_prev_q;

	// group affected by a local error
	always_comb
	begin
		if (mode == MODE_PARALLEL)
			ovl_grp = {4{|ovl_q}};
		else
			ovl_grp = {{2{|ovl_q[3:2]}}, {2{|ovl_q[1:0]}}};
	end

	// startup sequencer and fault latches
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		therm_d = therm_q;
		ovl_d = ovl_q;
		rst_prev_d = rst_s;
		case (state_q)
			// held until supplies are up, latches cleared
			ST_POWER_UP:
			begin
				ovl_d = 4'h0;
				therm_d = 1'b0;
				cnt_d = 32'h0;
				if (!low_supply)
				begin
					if (mode == MODE_SINGLE)
						state_d = ST_RUN;
					else
						state_d = ST_SHORT_GND;
				end
			end
			ST_SHORT_GND:
			begin
				if (cnt_q < phase_lim)
					cnt_d = cnt_q + 32'h1;
				else if (!(|sgnd_s))
				begin
					cnt_d = 32'h0;
					state_d = ST_SHORT_PVDD;
				end
			end
			// second phase: shorts to the stage supply
			ST_SHORT_PVDD:
			begin
				if (cnt_q < phase_lim)
					cnt_d = cnt_q + 32'h1;
				else if (!(|spv_s))
					state_d = ST_RUN;
			end
			// later shorts are not examined here
			ST_RUN:
			begin
				// cleared by reset, a new trip wins
				if (!rst_s)
					therm_d = 1'b0;
				if (rst_rise)
					ovl_d = 4'h0;
				if (t_trip_s)
					therm_d = 1'b1;
				ovl_d = ovl_d | oc_s;
			end
			default:
				state_d = ST_POWER_UP;
		endcase
		// only loss of the logic supply restarts the check
		if (!vdd_s)
			state_d = ST_POWER_UP;
	end

	// outputs of the protection logic
	always_comb
	begin
		hiz_d = {4{state_q != ST_RUN || !rst_s || therm_q || low_supply}};
		// local error group, bootstrap only its bridge
		hiz_d = hiz_d | ovl_grp | ~bst_s;
		// pulldown in reset, not single-ended, not in check
		pd_d = {4{!rst_s && mode != MODE_SINGLE && !checking}};
		// fault line low on shutdown faults
		if (checking)
			fault_low_d = 1'b1;
		else if (!rst_s)
			fault_low_d = 1'b0;
		else
			fault_low_d = therm_q || low_supply || (|ovl_q) ||
				state_q == ST_POWER_UP;
		wl_d = big_pkg && t_low_s;
		wh_d = big_pkg && t_high_s;
		wn_d = !big_pkg && t_high_s;
		ready_d = state_q == ST_RUN && rst_s && !(|oc_s) &&
			!therm_q && !low_supply && !(|ovl_q);
		clip_d = !clip_s;
	end

	// protection registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_POWER_UP;
			cnt_q <= 32'h0;
			therm_q <= 1'b0;
			ovl_q <= 4'h0;
			rst_prev_q <= 1'b1;
			hiz_q <= 4'hf;
			pd_q <= 4'h0;
			fault_low_q <= 1'b0;
			wl_q <= 1'b0;
			wh_q <= 1'b0;
			wn_q <= 1'b0;
			ready_q <= 1'b0;
			clip_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			therm_q <= therm_d;
			ovl_q <= ovl_d;
			rst_prev_q <= rst_prev_d;
			hiz_q <= hiz_d;
			pd_q <= pd_d;
			fault_low_q <= fault_low_d;
			wl_q <= wl_d;
			wh_q <= wh_d;
			wn_q <= wn_d;
			ready_q <= ready_d;
			clip_q <= clip_d;
		end
	end

	// open-drain lines only ever drive low
	assign fault_line_n_o = 1'b0;
	assign thermal_warn_low_n_o = 1'b0;
	assign thermal_warn_high_n_o = 1'b0;
	assign thermal_warn_n_o = 1'b0;
	assign fault_line_n_oe_n = !fault_low_q;
	assign thermal_warn_low_n_oe_n = !wl_q;
	assign thermal_warn_high_n_oe_n = !wh_q;
	assign thermal_warn_n_oe_n = !wn_q;
	assign bridge_hiz = hiz_q;
	assign weak_pulldown = pd_q;
	assign ready = ready_q;
	assign clip_n = clip_q;

	// bus slave state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d, stat;

	// status word showing the block's own state
	assign stat = {12'h0, lines_s, t_trip_s, t_high_s, t_low_s, ready_q,
		hiz_q, ovl_q, low_supply, therm_q, state_q == ST_RUN, checking};

	// bus next-state logic
	always_comb
	begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		// address and data taken in either order
		if (s_axi_awvalid && awready_q)
		begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q)
		begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		// response retires
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		// commit once both halves are held
		if (aw_have_q && w_have_q && !bvalid_q)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_SLVERR;
			if (awaddr_q[11:2] == REG_CTRL[11:2])
			begin
				bresp_d = RESP_OKAY;
				for (int b = 0; b < 4; b++)
					if (wstrb_q[b])
						ctrl_d[b*8 +: 8] = wdata_q[b*8 +: 8];
			end
			else if (awaddr_q[11:2] == REG_STAT[11:2])
				bresp_d = RESP_OKAY;
		end
		// read path
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			if (s_axi_araddr[11:2] == REG_CTRL[11:2])
				rdata_d = ctrl_q;
			else if (s_axi_araddr[11:2] == REG_STAT[11:2])
				rdata_d = stat;
			else
			begin
				rdata_d = 32'h0;
				rresp_d = RESP_SLVERR;
			end
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d = !w_have_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// bus registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 12'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0;
			ctrl_q <= CTRL_RST;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// checks on the protection behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	bst_only_a: assert property (
		state_q == ST_RUN && rst_s && !therm_q && !low_supply &&
		ovl_q == 4'h0 && bst_s != 4'hf |=> hiz_q == ~$past(bst_s))
		else $error("bootstrap fault spread past its bridge");
	short_hold_a: assert property (
		checking |=> hiz_q == 4'hf && fault_low_q)
		else $error("stage not off during short check");
	check_order_a: assert property (
		state_q == ST_SHORT_GND |=> state_q inside
		{ST_SHORT_GND, ST_SHORT_PVDD, ST_POWER_UP})
		else $error("short check phases out of order");
	no_restart_a: assert property (
		state_q == ST_RUN && vdd_s |=> state_q == ST_RUN)
		else $error("short check restarted without startup");
	se_skip_a: assert property (
		state_q == ST_POWER_UP && mode == MODE_SINGLE && !low_supply
		|=> state_q == ST_RUN)
		else $error("short check run in single-ended mode");
	therm_latch_a: assert property (
		therm_q && rst_s && state_q == ST_RUN |=> therm_q)
		else $error("thermal latch lost without reset");
	uv_off_a: assert property (
		low_supply && rst_s && state_q == ST_RUN
		|=> hiz_q == 4'hf && fault_low_q)
		else $error("undervoltage not shutting down");
	rst_off_a: assert property (
		!rst_s |=> hiz_q == 4'hf)
		else $error("stage active while reset low");
	sd_forced_a: assert property (
		!rst_s && !checking |=> !fault_low_q)
		else $error("fault line not forced high in reset");
	ready_oc_a: assert property (
		|oc_s |=> !ready_q ##1 !ready_q)
		else $error("ready high during overcurrent");
	group_a: assert property (
		mode == MODE_PARALLEL && |ovl_q |=> hiz_q == 4'hf)
		else $error("paralleled group not fully off");

	check_pass_c: cover property (
		state_q == ST_SHORT_PVDD ##1 state_q == ST_RUN);
	therm_trip_c: cover property (
		state_q == ST_RUN && !therm_q ##1 therm_q);
	ovl_clear_c: cover property (
		|ovl_q ##1 rst_rise ##1 ovl_q == 4'h0);
endmodule : amp_protection_fault_control

/* File: tb/amp_far_side.sv */
// far-side controller model: line pull-ups and reset pin timing
`timescale 1ns/100ps
module amp_far_side #(
	// shortened stand-in for the 4 ms wait
	parameter int HOLD_CYC = 20
)(
	// clock
	input wire logic aclk,
	// bench asks for reset held low
	input wire logic want_reset,
	// open-drain enables, fault line at bit 0
	input wire logic [3:0] line_oe_n,
	// resolved levels and reset pin
	output logic [3:0] line_lvl,
	output logic dev_reset_n
);
	// cycles since the fault line fell
	int since_fall = HOLD_CYC;
	// fault level one cycle ago
	logic prev_lvl = 1'b1;
	initial dev_reset_n = 1'b1;
	assign line_lvl = line_oe_n;
	// reset rises only after the hold time
	always @(posedge aclk)
	begin
		prev_lvl <= line_lvl[0];
		if (prev_lvl && !line_lvl[0])
			since_fall <= 0;
		else if (since_fall < HOLD_CYC)
			since_fall <= since_fall + 1;
		if (want_reset)
			dev_reset_n <= 1'b0;
		else if (since_fall >= HOLD_CYC)
			dev_reset_n <= 1'b1;
	end
endmodule : amp_far_side

/* File: tb/tb.sv */
// self-checking bench of the protection and fault-control block
`timescale 1ns/100ps
module tb
	import amp_prot_pkg::*;
;
	// row: {tl, th, clip} and expected {fault, low, high, clip_n}
	typedef logic [6:0] row_t;
	localparam logic [13:0] RUNNING = {4'h0, 4'h0, 2'b11, 4'hf};
	row_t rows [4] = '{7'h0f, 7'h4b, 7'h69, 7'h1e};
	// clock, reset and bus
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	// pin stimulus
	logic logic_ok = 1'b0, tl = 1'b0, th = 1'b0, tt = 1'b0;
	logic clip_in = 1'b0, want_reset = 1'b0;
	logic [3:0] gate_ok = 4'hf, boot_ok = 4'hf, oc = 4'h0;
	logic [3:0] sh_gnd = 4'h0, sh_sup = 4'h0;
	// device outputs and lines
	logic dev_reset_n, ready, clip_n;
	logic [3:0] line_oe_n, line_lvl, bridge_hiz, weak_pulldown;
	logic [13:0] pins;
	logic [3:0] warn_pic;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	assign pins = {bridge_hiz, weak_pulldown, ready, clip_n, line_lvl};
	// fault, low warning, high warning, clip in the row order
	assign warn_pic = {line_lvl[0], line_lvl[1], line_lvl[2], clip_n};
	// 50 MHz clock
	initial forever #10 aclk = ~aclk;
	amp_protection_fault_control #(.SC_CYC_PER_UF_P(8))
		u_amp_protection_fault_control (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.dev_reset_n(dev_reset_n), .logic_supply_ok(logic_ok),
		.gate_drive_supply_ok(gate_ok), .bootstrap_ok(boot_ok),
		.short_to_gnd(sh_gnd), .short_to_supply(sh_sup),
		.over_current_check(oc), .temp_over_low(tl),
		.temp_over_high(th), .temp_over_trip(tt), .clip_near(clip_in),
		.fault_line_n_i(line_lvl[0]), .fault_line_n_o(),
		.fault_line_n_oe_n(line_oe_n[0]),
		.thermal_warn_low_n_i(line_lvl[1]), .thermal_warn_low_n_o(),
		.thermal_warn_low_n_oe_n(line_oe_n[1]),
		.thermal_warn_high_n_i(line_lvl[2]), .thermal_warn_high_n_o(),
		.thermal_warn_high_n_oe_n(line_oe_n[2]),
		.thermal_warn_n_i(line_lvl[3]), .thermal_warn_n_o(),
		.thermal_warn_n_oe_n(line_oe_n[3]),
		.bridge_hiz(bridge_hiz), .weak_pulldown(weak_pulldown),
		.ready(ready), .clip_n(clip_n)
	);
	amp_far_side #(.HOLD_CYC(20)) u_amp_far_side (
		.aclk(aclk), .want_reset(want_reset), .line_oe_n(line_oe_n),
		.line_lvl(line_lvl), .dev_reset_n(dev_reset_n)
	);
	// verdict and end of run
	task automatic complete_run();
		$display("compares=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// compare the whole pin picture
	task automatic chk_pins(input logic [13:0] exp);
		chk(32'(pins), 32'(exp));
	endtask : chk_pins
	// bus write, response left in resp
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awready === 1'b1 && !aw_done)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w_done)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	// bus read into rd and resp
	task automatic axi_rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	// pin to output takes three edges, four through a fault latch
	task automatic settle();
		repeat (4) @(posedge aclk);
	endtask : settle
	// wait for switching to start
	task automatic wait_run();
		while (ready !== 1'b1)
			@(posedge aclk);
		settle();
	endtask : wait_run
	// ask the controller for reset low or high
	task automatic hold_rst(input logic v);
		@(posedge aclk);
		want_reset <= v;
		while (dev_reset_n !== !v)
			@(posedge aclk);
		settle();
	endtask : hold_rst
	// hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			fail_count++;
			complete_run();
		end
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge aclk);
		chk_pins({4'hf, 4'h0, 2'b01, 4'hf});
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// register access and refusals
		axi_rd(REG_CTRL);
		chk(rd, CTRL_RST);
		axi_rd(12'hffc);
		chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
		axi_wr(12'h800, 32'hffff_ffff);
		chk(32'(resp), 32'(RESP_SLVERR));
		axi_wr(REG_STAT, 32'hffff_ffff);
		chk(32'(resp), 32'(RESP_OKAY));
		// startup with a ground short, then a supply short
		sh_gnd <= 4'h2;
		logic_ok <= 1'b1;
		repeat (40) @(posedge aclk);
		chk(32'({bridge_hiz, line_lvl[0]}), 32'h1e);
		sh_gnd <= 4'h0;
		sh_sup <= 4'h4;
		repeat (40) @(posedge aclk);
		axi_rd(REG_STAT);
		chk(32'({rd[1:0], bridge_hiz}), 32'h1f);
		sh_sup <= 4'h0;
		wait_run();
		chk_pins(RUNNING);
		// a short after startup is not looked at
		sh_gnd <= 4'hf;
		settle();
		chk_pins(RUNNING);
		sh_gnd <= 4'h0;
		// warning and clip table
		foreach (rows[i])
		begin
			{tl, th, clip_in} <= rows[i][6:4];
			settle();
			chk(32'(warn_pic), 32'(rows[i][3:0]));
		end
		{tl, th, clip_in} <= 3'b000;
		// overcurrent on A turns off A and B, latched
		oc <= 4'h1;
		settle();
		oc <= 4'h0;
		settle();
		chk_pins({4'h3, 4'h0, 2'b01, 4'he});
		hold_rst(1'b1);
		chk_pins({4'hf, 4'hf, 2'b01, 4'hf});
		hold_rst(1'b0);
		chk_pins(RUNNING);
		// thermal shutdown latches until reset
		{tl, th, tt} <= 3'b111;
		settle();
		{tl, th, tt} <= 3'b000;
		settle();
		chk(32'({bridge_hiz, line_lvl[0]}), 32'h1e);
		hold_rst(1'b1);
		hold_rst(1'b0);
		chk_pins(RUNNING);
		// gate supply dip recovers alone
		gate_ok <= 4'hb;
		settle();
		chk(32'({bridge_hiz, line_lvl[0]}), 32'h1e);
		gate_ok <= 4'hf;
		wait_run();
		chk_pins(RUNNING);
		// bootstrap dip turns off its own half-bridge only
		boot_ok <= 4'hd;
		settle();
		chk(32'({bridge_hiz, line_lvl[0]}), 32'h05);
		boot_ok <= 4'hf;
		settle();
		// paralleled bridges: a local error turns off all four
		axi_wr(REG_CTRL, 32'h0000_0105);
		oc <= 4'h4;
		settle();
		oc <= 4'h0;
		settle();
		chk_pins({4'hf, 4'h0, 2'b01, 4'he});
		hold_rst(1'b1);
		hold_rst(1'b0);
		chk_pins(RUNNING);
		// smaller package uses the single warning line
		axi_wr(REG_CTRL, 32'h0000_0100);
		{tl, th} <= 2'b11;
		settle();
		chk(32'(line_lvl), 32'h7);
		{tl, th} <= 2'b00;
		// single-ended: no pulldown, no short check
		axi_wr(REG_CTRL, 32'h0000_0106);
		hold_rst(1'b1);
		chk(32'({bridge_hiz, weak_pulldown}), 32'hf0);
		hold_rst(1'b0);
		sh_gnd <= 4'hf;
		logic_ok <= 1'b0;
		settle();
		logic_ok <= 1'b1;
		wait_run();
		chk_pins(RUNNING);
		complete_run();
	end
endmodule : tb
